// ===== core/osc_ctrl.sv
/*
 Oscillator select control register block with Avalon-MM slave, unlock
 gate, selection lock, PLL lock status and interrupt status/mask.
 Assumes config word and PLL lock levels arrive asynchronously from pins.
*/
// Added by the designer: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/10ps
module osc_ctrl
   import osc_pkg::*;
#(
   parameter int SETTLE = OSC_SWITCH_CYC
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Avalon-MM slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Configuration word one fields
   input wire logic [2:0] initial_source_cfg,
   input wire logic [1:0] switch_monitor_cfg,
   // PLL status from analog
   input wire logic sys_pll_lock_in,
   input wire logic sys_pll_timer_done,
   input wire logic usb_pll_lock_in,
   input wire logic usb_pll_timer_done,
   // Oscillator controls
   output logic [2:0] pll_multiplier,
   output logic [2:0] fast_rc_divider,
   output logic [2:0] current_source,
   output logic switch_busy,
   output logic sleep_on_wait,
   output logic irq
);
   osc_bus_req_type req;
   osc_bus_rsp_type rsp;
   logic [8:0] sync1_ff;
   logic [8:0] sync2_ff;
   logic [2:0] init_src;
   logic [1:0] monitor_cfg;
   logic usb_pll_locked;
   logic sys_pll_locked;
   logic sys_locked_d_ff;
   logic [2:0] requested_source_ff;
   logic [2:0] mult_ff;
   logic [2:0] div_ff;
   logic selection_lock_ff;
   logic sleep_ff;
   logic [1:0] unlock_ff;
   logic [OSC_IRQ_W-1:0] status_ff;
   logic [OSC_IRQ_W-1:0] mask_ff;
   logic [OSC_IRQ_W-1:0] nxt_status;
   logic ack_ff;
   logic [31:0] readdata_ff;
   logic [31:0] control_word;
   logic wr_ctl;
   logic wr_unl;
   logic ctl_open;
   logic sel_frozen;
   logic bad_write;
   logic sw_done;
   logic [2:0] cur_src;

   assign req = '{address: avs_address, read: avs_read, write: avs_write,
      writedata: avs_writedata};

   // Pins cross in through two flops before anything looks at them
   always_ff @(posedge clk)
   begin
      sync1_ff <= {usb_pll_timer_done, usb_pll_lock_in, sys_pll_timer_done,
         sys_pll_lock_in, initial_source_cfg, switch_monitor_cfg};
      sync2_ff <= sync1_ff;
   end
   assign monitor_cfg = sync2_ff[1:0];
   // Config word goes through the pair too: reset must last three edges
   assign init_src = sync2_ff[4:2];
   assign sys_pll_locked = sync2_ff[5] | sync2_ff[6];
   assign usb_pll_locked = sync2_ff[7] | sync2_ff[8];

   // One-cycle answer: waitrequest high in the first cycle of a request
   always_ff @(posedge clk)
   begin
      if (rst)
         ack_ff <= 1'b0;
      else
         ack_ff <= (req.read | req.write) & ~ack_ff;
   end
   assign rsp.waitrequest = (req.read | req.write) & ~ack_ff;
   assign rsp.readdata = readdata_ff;
   assign avs_waitrequest = rsp.waitrequest;
   assign avs_readdata = rsp.readdata;

   assign wr_ctl = req.write & ack_ff && req.address == OSC_ADDR_CONTROL;
   assign wr_unl = req.write & ack_ff && req.address == OSC_ADDR_UNLOCK;
   assign ctl_open = (unlock_ff == 2'h2);
   assign sel_frozen = monitor_cfg[1] & selection_lock_ff;
   assign bad_write = wr_ctl & ~ctl_open;

   // Unlock sequence: two keys back to back, any other write disarms
   always_ff @(posedge clk)
   begin
      if (rst)
         unlock_ff <= 2'h0;
      else if (wr_unl && unlock_ff == 2'h0 && req.writedata == OSC_KEY_FIRST)
         unlock_ff <= 2'h1;
      else if (wr_unl && unlock_ff == 2'h1 && req.writedata == OSC_KEY_SECOND)
         unlock_ff <= 2'h2;
      else if (req.write & ack_ff)
         unlock_ff <= 2'h0;
   end

   // Lock bit once set stays until reset while frozen
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         requested_source_ff <= init_src;
         mult_ff <= OSC_RST_MULT;
         div_ff <= OSC_RST_DIV;
         selection_lock_ff <= 1'b0;
         sleep_ff <= 1'b0;
      end
      else if (wr_ctl && ctl_open)
      begin
         if (!sel_frozen)
         begin
            requested_source_ff <= req.writedata[OSC_POS_REQ+:3];
            mult_ff <= req.writedata[OSC_POS_MULT+:3];
            div_ff <= req.writedata[OSC_POS_DIV+:3];
            selection_lock_ff <= req.writedata[OSC_POS_LOCK];
         end
         sleep_ff <= req.writedata[OSC_POS_SLEEP];
      end
   end

   osc_switch #(
      .SETTLE(SETTLE)
   ) u_switch (
      .clk(clk),
      .rst(rst),
      .requested_source(requested_source_ff),
      .initial_source(init_src),
      .current_source(cur_src),
      .switch_busy(switch_busy),
      .switch_done(sw_done)
   );

   // Bits 15 and 11 and all unlisted bits read zero
   always_comb
   begin
      control_word = 32'h00000000;
      control_word[OSC_POS_DIV+:3] = div_ff;
      control_word[OSC_POS_MULT+:3] = mult_ff;
      control_word[OSC_POS_CUR+:3] = cur_src;
      control_word[OSC_POS_REQ+:3] = requested_source_ff;
      control_word[OSC_POS_LOCK] = selection_lock_ff;
      control_word[OSC_POS_USB_PLL_LOCKED] = usb_pll_locked;
      control_word[OSC_POS_SYS_PLL_LOCKED] = sys_pll_locked;
      control_word[OSC_POS_SLEEP] = sleep_ff;
   end

   // Events: bit0 switch done, bit1 system PLL lock changed, bit2 bad write
   always_comb
   begin
      nxt_status = status_ff;
      // Clear only what the read returned, so a later event is not lost
      if (req.read && ack_ff && req.address == OSC_ADDR_IRQ_STATUS)
         nxt_status = status_ff & ~readdata_ff[OSC_IRQ_W-1:0];
      // Set wins over the read clear
      nxt_status = nxt_status | {bad_write,
         sys_pll_locked ^ sys_locked_d_ff, sw_done};
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         status_ff <= '0;
         mask_ff <= '0;
         sys_locked_d_ff <= 1'b0;
      end
      else
      begin
         status_ff <= nxt_status;
         sys_locked_d_ff <= sys_pll_locked;
         if (req.write && ack_ff && req.address == OSC_ADDR_IRQ_MASK)
            mask_ff <= req.writedata[OSC_IRQ_W-1:0];
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         readdata_ff <= 32'h00000000;
      else if (req.read && !ack_ff)
         unique case (req.address)
            OSC_ADDR_CONTROL: readdata_ff <= control_word;
            OSC_ADDR_UNLOCK: readdata_ff <= {30'h0, unlock_ff};
            OSC_ADDR_IRQ_STATUS: readdata_ff <= {29'h0, status_ff};
            OSC_ADDR_IRQ_MASK: readdata_ff <= {29'h0, mask_ff};
            default: readdata_ff <= 32'h00000000;
         endcase
   end

   assign pll_multiplier = mult_ff;
   assign fast_rc_divider = div_ff;
   assign current_source = cur_src;
   assign sleep_on_wait = sleep_ff;
   assign irq = |(status_ff & mask_ff);
endmodule

// ===== core/osc_pkg.sv
/*
 Package for the oscillator select control block: register map, field
 positions, reset values, source encoding and the unlock sequence.
 Assumes a 32-bit Avalon-MM slave with word addressing.
*/
package osc_pkg;
   localparam logic [3:0] OSC_ADDR_CONTROL = 4'h0;
   localparam logic [3:0] OSC_ADDR_UNLOCK = 4'h1;
   localparam logic [3:0] OSC_ADDR_IRQ_STATUS = 4'h2;
   localparam logic [3:0] OSC_ADDR_IRQ_MASK = 4'h3;
   localparam logic [31:0] OSC_KEY_FIRST = 32'haa996655;
   localparam logic [31:0] OSC_KEY_SECOND = 32'h556699aa;
   localparam int OSC_POS_DIV = 24;
   localparam int OSC_POS_MULT = 16;
   localparam int OSC_POS_CUR = 12;
   localparam int OSC_POS_REQ = 8;
   localparam int OSC_POS_LOCK = 7;
   localparam int OSC_POS_USB_PLL_LOCKED = 6;
   localparam int OSC_POS_SYS_PLL_LOCKED = 5;
   localparam int OSC_POS_SLEEP = 4;
   localparam logic [2:0] OSC_RST_MULT = 3'h0;
   localparam logic [2:0] OSC_RST_DIV = 3'h0;
   // Time in ns the new source is given to settle before the switch completes, rounded up to clock cycles
   localparam int OSC_SWITCH_NS = 200;
   localparam int OSC_CLK_NS = 20;
   localparam int OSC_SWITCH_CYC = (OSC_SWITCH_NS + OSC_CLK_NS - 1) /
      OSC_CLK_NS;
   // Interrupt bits: switch done, system PLL lock change, control write without unlock
   localparam int OSC_IRQ_W = 3;

   typedef enum logic [2:0] {
      OSC_SRC_FRC = 3'h0,
      OSC_SRC_FRC_PLL = 3'h1,
      OSC_SRC_PRI = 3'h2,
      OSC_SRC_PRI_PLL = 3'h3,
      OSC_SRC_SEC = 3'h4,
      OSC_SRC_LOW_POWER_INTERNAL_RC = 3'h5,
      OSC_SRC_FRC_DIV16 = 3'h6,
      OSC_SRC_FRC_DIVN = 3'h7
   } osc_src_type;

   typedef struct packed {
      logic [3:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
   } osc_bus_req_type;

   typedef struct packed {
      logic [31:0] readdata;
      logic waitrequest;
   } osc_bus_rsp_type;

   function automatic logic [4:0] osc_mult_factor(input logic [2:0] code);
      osc_mult_factor = (code == 3'h7) ? 5'h18 : 5'h0f + {2'h0, code};
   endfunction
endpackage

// ===== core/osc_switch.sv
/*
 Source switch sequencer: after a requested source differs from the current
 one, waits a settle count and then adopts the requested source.
 Assumes request input is stable while a switch is running.
*/
`timescale 1ns/10ps
module osc_switch
   import osc_pkg::*;
#(
   parameter int SETTLE = OSC_SWITCH_CYC
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Request and status
   input wire logic [2:0] requested_source,
   input wire logic [2:0] initial_source,
   output logic [2:0] current_source,
   output logic switch_busy,
   output logic switch_done
);
   typedef enum logic {SW_IDLE, SW_WAIT} osc_sw_state_type;
   osc_sw_state_type state_ff;
   logic [15:0] count_ff;
   logic [2:0] current_ff;
   logic done_ff;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_ff <= SW_IDLE;
         count_ff <= 16'h0000;
         done_ff <= 1'b0;
      end
      else
      begin
         done_ff <= 1'b0;
         unique case (state_ff)
            SW_IDLE:
               if (requested_source != current_ff)
               begin
                  state_ff <= SW_WAIT;
                  count_ff <= 16'h0000;
               end
            SW_WAIT:
               if (count_ff == 16'(SETTLE - 1))
               begin
                  state_ff <= SW_IDLE;
                  done_ff <= 1'b1;
               end
               else
                  count_ff <= count_ff + 16'h0001;
         endcase
      end
   end

   // Current source tracks the configured start source through reset
   always_ff @(posedge clk)
   begin
      if (rst)
         current_ff <= initial_source;
      else if (state_ff == SW_WAIT && count_ff == 16'(SETTLE - 1))
         current_ff <= requested_source;
   end

   assign current_source = current_ff;
   assign switch_busy = (state_ff == SW_WAIT);
   assign switch_done = done_ff;
endmodule

// ===== test/osc_ctrl_bench.sv
/*
 Self-checking bench for osc_ctrl against a register model.
 Assumes the switch settle count is shortened to 2 cycles.
*/
`timescale 1ns/10ps
module osc_ctrl_bench import osc_pkg::*;;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] adr = 4'h0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [2:0] init_src = 3'h5;
   logic [1:0] cfg = 2'h0;
   // Sys lock, sys timer, usb lock, usb timer
   logic [3:0] pll = 4'h0;
   logic [31:0] rdata, got, d;
   logic [2:0] mult, div, cur, m_req, m_mult, m_div;
   logic wait_req, busy, sleep, irq, m_lock, m_sleep;
   int fail_count = 0;
   int n_tests = 0;
   int seed = 32'h69fb;
   always #10 clk = ~clk;
   osc_ctrl #(.SETTLE(2)) osc_ctrl_inst (.clk(clk), .rst(rst),
      .avs_address(adr), .avs_read(rd), .avs_write(wr),
      .avs_writedata(wdata), .avs_readdata(rdata),
      .avs_waitrequest(wait_req), .initial_source_cfg(init_src),
      .switch_monitor_cfg(cfg), .sys_pll_lock_in(pll[3]),
      .sys_pll_timer_done(pll[2]), .usb_pll_lock_in(pll[1]),
      .usb_pll_timer_done(pll[0]), .pll_multiplier(mult),
      .fast_rc_divider(div), .current_source(cur), .switch_busy(busy),
      .sleep_on_wait(sleep), .irq(irq));
   function automatic logic [31:0] exp_ctrl;
      exp_ctrl = {5'h0, m_div, 5'h0, m_mult, 1'b0, m_req, 1'b0, m_req,
         m_lock, pll[1] | pll[0], pll[3] | pll[2], m_sleep, 4'h0};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      n_tests++;
      if (seen !== want)
      begin
         fail_count++;
         $display("CHECK FAILED %0t seen %h want %h", $time, seen, want);
      end
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Holds the request until waitrequest is seen low, then one idle edge
   task automatic bus(input logic w, input logic [3:0] a,
      input logic [31:0] v);
      int k;
      adr <= a;
      wr <= w;
      rd <= !w;
      wdata <= v;
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (wait_req !== 1'b0 && k < 20);
      if (k >= 20)
      begin
         fail_count++;
         stop_test();
      end
      got = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic settle;
      int k;
      repeat (3) @(posedge clk);
      for (k = 0; k < 50 && busy !== 1'b0; k++)
         @(posedge clk);
      if (k >= 50)
      begin
         fail_count++;
         stop_test();
      end
   endtask
   task automatic ctrl_write(input logic [31:0] v);
      bus(1'b1, OSC_ADDR_UNLOCK, OSC_KEY_FIRST);
      bus(1'b1, OSC_ADDR_UNLOCK, OSC_KEY_SECOND);
      bus(1'b1, OSC_ADDR_CONTROL, v);
      if (!(cfg[1] && m_lock))
         {m_div, m_mult, m_req, m_lock} = {v[26:24], v[18:16], v[10:8], v[7]};
      m_sleep = v[4];
      settle();
      bus(1'b0, OSC_ADDR_CONTROL, 32'h0);
   endtask
   initial
   begin
      {m_div, m_mult, m_req, m_lock, m_sleep} = {6'h00, init_src, 2'h0};
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      settle();
      bus(1'b0, OSC_ADDR_CONTROL, 32'h0);
      check(got, exp_ctrl());
      $display("reset test done");
      for (int i = 0; i < 16; i++)
      begin
         pll <= i[3:0];
         d = $random(seed);
         d[18:16] = i[2:0];
         d[10:8] = i[2:0];
         ctrl_write(d);
         check(got, exp_ctrl());
         check({22'h0, mult, div, cur, sleep},
            {22'h0, m_mult, m_div, m_req, m_sleep});
      end
      $display("code sweep test done");
      bus(1'b0, OSC_ADDR_IRQ_STATUS, 32'h0);
      bus(1'b1, OSC_ADDR_IRQ_MASK, 32'h4);
      bus(1'b1, OSC_ADDR_CONTROL, ~exp_ctrl());
      check({31'h0, irq}, 32'h1);
      bus(1'b1, OSC_ADDR_UNLOCK, OSC_KEY_FIRST);
      bus(1'b1, OSC_ADDR_CONTROL, ~exp_ctrl());
      bus(1'b0, OSC_ADDR_IRQ_STATUS, 32'h0);
      check(got & 32'h4, 32'h4);
      check({31'h0, irq}, 32'h0);
      bus(1'b1, OSC_ADDR_IRQ_MASK, 32'h1);
      ctrl_write(exp_ctrl() ^ 32'h100);
      check({31'h0, irq}, 32'h1);
      bus(1'b1, OSC_ADDR_CONTROL, ~exp_ctrl());
      bus(1'b0, OSC_ADDR_CONTROL, 32'h0);
      check(got, exp_ctrl());
      bus(1'b1, 4'h9, 32'hffffffff);
      bus(1'b0, 4'h9, 32'h0);
      check(got, 32'h0);
      $display("refusal and interrupt test done");
      cfg <= 2'h2;
      ctrl_write(32'h00020280);
      ctrl_write(32'h00050410);
      check(got, exp_ctrl());
      cfg <= 2'h1;
      ctrl_write(32'h00050410);
      check(got, exp_ctrl());
      $display("lock test done");
      stop_test();
   end
endmodule

// ===== test/osc_ctrl_monitor.sv
/*
 Port checker for the oscillator select control block.
 Assumes it is bound into osc_ctrl and sees only its ports.
*/
`timescale 1ns/10ps
module osc_ctrl_monitor
   import osc_pkg::*;
#(
   parameter int SETTLE = OSC_SWITCH_CYC
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Bus
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // Controls
   input wire logic [2:0] pll_multiplier,
   input wire logic [2:0] fast_rc_divider,
   input wire logic [2:0] current_source,
   input wire logic switch_busy,
   input wire logic sleep_on_wait
);
   localparam int SETTLE_MAX = SETTLE + 3;
   logic ctrl_wr;
   logic rd_ok;
   assign ctrl_wr = avs_write && !avs_waitrequest && avs_address == 4'h0;
   assign rd_ok = avs_read && !avs_waitrequest;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence req_new;
      $rose(avs_read) || $rose(avs_write);
   endsequence
   sequence one_wait;
      avs_waitrequest ##1 !avs_waitrequest;
   endsequence
   wait_one_a: assert property (req_new |-> one_wait)
      else $error("request wait not one cycle");
   idle_nowait_a: assert property (!avs_read && !avs_write |->
      !avs_waitrequest) else $error("wait while idle");
   mult_cause_a: assert property ($changed(pll_multiplier) |->
      $past(ctrl_wr)) else $error("multiplier moved without write");
   div_cause_a: assert property ($changed(fast_rc_divider) |->
      $past(ctrl_wr)) else $error("divider moved without write");
   sleep_cause_a: assert property ($changed(sleep_on_wait) |->
      $past(ctrl_wr)) else $error("sleep moved without write");
   cur_cause_a: assert property ($changed(current_source) |->
      $past(switch_busy)) else $error("source moved while not busy");
   busy_bound_a: assert property ($rose(switch_busy) |->
      ##[1:SETTLE_MAX] !switch_busy) else $error("switch too long");
   ctrl_zero_a: assert property (rd_ok && avs_address == 4'h0 |->
      avs_readdata[31:27] == 5'h0 && avs_readdata[23:19] == 5'h0 &&
      !avs_readdata[15] && !avs_readdata[11] && avs_readdata[3:0] == 4'h0)
      else $error("unused control bits set");
   unmapped_zero_a: assert property (rd_ok && avs_address > 4'h3 |->
      avs_readdata == 32'h0) else $error("unmapped read not zero");
endmodule

bind osc_ctrl osc_ctrl_monitor #(.SETTLE(SETTLE)) osc_ctrl_monitor_inst (
   .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .pll_multiplier(pll_multiplier),
   .fast_rc_divider(fast_rc_divider), .current_source(current_source),
   .switch_busy(switch_busy), .sleep_on_wait(sleep_on_wait));
